// >>> rtl/dgm_cfg.svh
`ifndef DGM_CFG_SVH
`define DGM_CFG_SVH
// clock and start-up timing
`define DGM_CLK_HZ 20000000
`define DGM_TICK_US 1000
`define DGM_TICK_CYC (`DGM_CLK_HZ / 1000000 * `DGM_TICK_US)
`define DGM_LAMP_MS 200
// wishbone register offsets (byte addresses)
`define DGM_REG_CTRL 8'h00
`define DGM_REG_STATUS 8'h04
`define DGM_REG_IRQ 8'h08
`define DGM_REG_DIAG0 8'h0c
`define DGM_REG_DIAG1 8'h10
`define DGM_REG_DIAG2 8'h14
// control register fields
`define DGM_CTRL_DIAG_EN 0
`define DGM_CTRL_INCR 1
`define DGM_CTRL_RUN 2
`define DGM_CTRL_OUT_REQ 3
`define DGM_CTRL_RESET 4'h0
// interrupt register fields
`define DGM_IRQ_PEND 0
`define DGM_IRQ_OUTGOING 1
// error source bits
`define DGM_ERR_AUX 0
`define DGM_ERR_FRONT 1
`define DGM_ERR_PULSE 2
`define DGM_ERR_WIRE 3
`define DGM_ERR_TRAV 4
`define DGM_ERR_FEEDBK 5
`define DGM_ERR_WORK 6
`define DGM_ERR_WDOG 7
`define DGM_MASK_INT 8'h80
`define DGM_MASK_EXT 8'h7f
`define DGM_MASK_CHAN 8'h7c
`define DGM_MASK_INCR_SYNC 8'h0f
`define DGM_MASK_ALL_SYNC 8'h30
`define DGM_MASK_RANGE 8'h50
// self test
`define DGM_RAM_DEPTH 16
`define DGM_RAM_PAT 8'ha5
`define DGM_ROM_SIG 8'h00
`endif

// >>> rtl/dgm_monitor.sv
`timescale 1ns/1ps
`include "dgm_cfg.svh"
// What this block does
// - power-on self test of ram and program store
// - lamp test both, then internal, then off
// - failed test: safe state, internal indicator on
// - incoming error: indicator plus module-fault flag bit0
// - incoming while any monitored error pending
// - partial clear re-signals remaining errors incoming
// - outgoing only when last error clears
// - interrupts only when host enabled them
// - interrupt error aborts positioning at once
// - incremental encoder: clear sync on listed errors
// - any encoder: clear sync on range, feedback
// - no new traverse; jog allowed after range-left
// - interrupt error switches control outputs off
// - detail record starts with start information
// - all clear: interrupt, indicators off, flag 0
// - incoming lights group indicator, channel indicators for channel errors
// - host stopped inhibits; run re-signals pending only
module dgm_monitor
  import dgm_pkg::*;
#(
  parameter int TICK_CYC = `DGM_TICK_CYC,
  parameter int LAMP_MS = `DGM_LAMP_MS,
  parameter int NERR = 8
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  input wire logic [NERR-1:0] ERR_SRC_I,
  input wire logic [NERR-1:0] ERR_CH2_I,
  input wire logic TEST_INJECT_I,
  output logic INT_FAULT_O,
  output logic EXT_FAULT_O,
  output logic GROUP_FAULT_O,
  output logic CH1_O,
  output logic CH2_O,
  output logic DIAG_INT_O,
  output logic POS_ABORT_O,
  output logic SYNC_CLR_O,
  output logic OUT_EN_O,
  output logic TRAVERSE_OK_O,
  output logic JOG_OK_O,
  output logic READY_O
);
  dgm_state_t state_q;
  logic tick;
  logic test_done;
  logic test_pass;
  logic [15:0] ms_q;
  logic [3:0] ctrl_q;
  logic [NERR-1:0] pend_q;
  logic [NERR-1:0] prev_q;
  logic [NERR-1:0] chan_q;
  logic [NERR-1:0] reported_q;
  logic irq_q;
  logic outgoing_q;
  logic run_q;
  dgm_info_t info_q;
  dgm_info_t info_d;
  logic [NERR-1:0] detail_err_q;
  logic [NERR-1:0] detail_ch_q;
  dgm_leds_t leds_d;
  logic running;
  logic diag_en;
  logic host_run;
  logic incr;
  logic new_err;
  logic raise_in;
  logic raise_out;
  logic quiet_clear;
  logic raise;
  logic bus_req;
  logic wr;
  logic ack_wr;
  logic mapped;

  assign running = (state_q == ST_RUN);
  assign diag_en = ctrl_q[`DGM_CTRL_DIAG_EN];
  assign host_run = ctrl_q[`DGM_CTRL_RUN];
  assign incr = ctrl_q[`DGM_CTRL_INCR];

  dgm_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .tick_o(tick)
  );

  dgm_selftest #(
    .DEPTH(`DGM_RAM_DEPTH)
  ) u_test (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .start_i(state_q == ST_TEST),
    .inject_i(TEST_INJECT_I),
    .done_o(test_done),
    .pass_o(test_pass)
  );

  // start-up sequencer: lamp phase, then memory test, then run or fail
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_q <= ST_LAMP;
      ms_q <= 16'h0;
    end else begin
      unique case (state_q)
        ST_LAMP: begin
          if (tick) ms_q <= ms_q + 16'h1;
          if (ms_q == 16'(LAMP_MS)) state_q <= ST_TEST;
        end
        ST_TEST: if (test_done) begin
          state_q <= test_pass ? ST_RUN : ST_FAIL;
        end
        ST_RUN: state_q <= ST_RUN;
        ST_FAIL: state_q <= ST_FAIL; // only reset leaves this
      endcase
    end
  end

  // error sources sampled once so that every consumer sees one set
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      pend_q <= '0;
      prev_q <= '0;
    end else begin
      pend_q <= running ? ERR_SRC_I : '0;
      prev_q <= pend_q;
    end
  end

  // channel map sampled in step with the errors it qualifies
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      chan_q <= '0;
    end else begin
      chan_q <= ERR_CH2_I;
    end
  end

  assign new_err = |(pend_q & ~prev_q);
  // interrupt decision compares against what was last reported
  assign raise_in = diag_en && host_run && (pend_q != '0)
    && ((pend_q != reported_q) || (host_run && !run_q));
  assign raise_out = diag_en && host_run && run_q && (pend_q == '0)
    && (reported_q != '0);
  // errors cleared while stopped are dropped without an interrupt
  assign quiet_clear = host_run && !run_q && (pend_q == '0);
  assign raise = raise_in || raise_out;

  always_comb begin
    info_d = '0;
    info_d.module_fault = |pend_q;
    info_d.int_err = |(pend_q & NERR'(`DGM_MASK_INT));
    info_d.ext_err = |(pend_q & NERR'(`DGM_MASK_EXT));
    info_d.chan_err = |(pend_q & NERR'(`DGM_MASK_CHAN));
    info_d.errs = 8'(pend_q);
    info_d.chan = {6'h0, |(pend_q & chan_q & NERR'(`DGM_MASK_CHAN)),
      |(pend_q & ~chan_q & NERR'(`DGM_MASK_CHAN))};
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      run_q <= 1'b0;
    end else begin
      run_q <= host_run;
    end
  end

  // interrupt request stands until the host acknowledges it
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      irq_q <= 1'b0;
      outgoing_q <= 1'b0;
    end else if (raise) begin
      irq_q <= 1'b1; // a new event wins over a same-cycle ack
      outgoing_q <= raise_out;
    end else if (ack_wr && DAT_I[`DGM_IRQ_PEND]) begin
      irq_q <= 1'b0;
    end
  end

  // last reported set; dropped silently when errors vanished during a stop
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      reported_q <= '0;
    end else if (raise) begin
      reported_q <= pend_q;
    end else if (quiet_clear) begin
      reported_q <= '0;
    end
  end

  // start information and detail record are latched with the event itself
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      info_q <= '0;
      detail_err_q <= '0;
      detail_ch_q <= '0;
    end else if (raise) begin
      info_q <= info_d;
      detail_err_q <= pend_q;
      detail_ch_q <= chan_q;
    end
  end

  // safe-state reactions; they act even when interrupts are masked
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      POS_ABORT_O <= 1'b0;
      SYNC_CLR_O <= 1'b0;
    end else begin
      POS_ABORT_O <= new_err;
      SYNC_CLR_O <= (incr && |(pend_q & ~prev_q & NERR'(`DGM_MASK_INCR_SYNC)))
        || |(pend_q & ~prev_q & NERR'(`DGM_MASK_ALL_SYNC));
    end
  end

  // outputs stay off until every error is gone and the host asks for them
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      OUT_EN_O <= 1'b0;
    end else begin
      OUT_EN_O <= running && ctrl_q[`DGM_CTRL_OUT_REQ] && (pend_q == '0)
        && !new_err;
    end
  end

  // jogging stays possible while only range-left errors are pending
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      TRAVERSE_OK_O <= 1'b0;
      JOG_OK_O <= 1'b0;
    end else begin
      TRAVERSE_OK_O <= running && (pend_q == '0);
      JOG_OK_O <= running && ((pend_q & ~NERR'(`DGM_MASK_RANGE)) == '0);
    end
  end

  always_comb begin
    leds_d = '0;
    unique case (state_q)
      ST_LAMP: begin
        leds_d.int_ind = 1'b1;
        leds_d.ext_ind = 1'b1;
      end
      ST_TEST: leds_d.int_ind = 1'b1;
      ST_FAIL: leds_d.int_ind = 1'b1;
      ST_RUN: begin
        leds_d.int_ind = info_d.int_err;
        leds_d.ext_ind = info_d.ext_err;
        leds_d.group_ind = info_d.module_fault;
        leds_d.ch1_ind = info_d.chan[0];
        leds_d.ch2_ind = info_d.chan[1];
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      INT_FAULT_O <= 1'b1;
      EXT_FAULT_O <= 1'b1;
      GROUP_FAULT_O <= 1'b0;
      CH1_O <= 1'b0;
      CH2_O <= 1'b0;
    end else begin
      INT_FAULT_O <= leds_d.int_ind;
      EXT_FAULT_O <= leds_d.ext_ind;
      GROUP_FAULT_O <= leds_d.group_ind;
      CH1_O <= leds_d.ch1_ind;
      CH2_O <= leds_d.ch2_ind;
    end
  end

  // a stopped host sees no request; a pending one is kept for the return to run
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      DIAG_INT_O <= 1'b0;
    end else begin
      DIAG_INT_O <= host_run && (irq_q || raise);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      READY_O <= 1'b0;
    end else begin
      READY_O <= running;
    end
  end

  // wishbone slave: one wait state, error answer when refused
  assign bus_req = CYC_I && STB_I && !ACK_O && !ERR_O;
  assign mapped = (ADR_I == `DGM_REG_CTRL) || (ADR_I == `DGM_REG_STATUS)
    || (ADR_I == `DGM_REG_IRQ) || (ADR_I == `DGM_REG_DIAG0)
    || (ADR_I == `DGM_REG_DIAG1) || (ADR_I == `DGM_REG_DIAG2);
  // a failed device answers every access with an error
  assign wr = bus_req && WE_I && mapped && running && SEL_I[0];
  assign ack_wr = wr && (ADR_I == `DGM_REG_IRQ);

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ctrl_q <= `DGM_CTRL_RESET;
    end else if (wr && ADR_I == `DGM_REG_CTRL) begin
      ctrl_q <= DAT_I[3:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
    end else begin
      ACK_O <= bus_req && mapped && (state_q != ST_FAIL);
      ERR_O <= bus_req && (!mapped || state_q == ST_FAIL);
    end
  end

  // read data is zero outside ack so several slaves can share one return bus
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      DAT_O <= 32'h0;
    end else begin
      DAT_O <= 32'h0;
      if (bus_req && !WE_I && mapped && state_q != ST_FAIL) begin
        unique case (ADR_I)
          `DGM_REG_CTRL: DAT_O <= {28'h0, ctrl_q};
          `DGM_REG_STATUS: DAT_O <= {16'h0, 8'(pend_q), 6'h0, state_q};
          `DGM_REG_IRQ: DAT_O <= {30'h0, outgoing_q, irq_q};
          `DGM_REG_DIAG0: DAT_O <= info_q;
          `DGM_REG_DIAG1: DAT_O <= {24'h0, 8'(detail_err_q)};
          `DGM_REG_DIAG2: DAT_O <= {24'h0, 8'(detail_ch_q)};
          default: DAT_O <= 32'h0;
        endcase
      end
    end
  end
endmodule

// >>> rtl/dgm_pkg.sv
package dgm_pkg;
  typedef enum logic [1:0] {
    ST_LAMP = 2'b00,
    ST_TEST = 2'b01,
    ST_RUN = 2'b10,
    ST_FAIL = 2'b11
  } dgm_state_t;

  // four-byte interrupt start information
  typedef struct packed {
    logic [7:0] chan;
    logic [7:0] errs;
    logic [7:0] spare;
    logic [3:0] zero;
    logic chan_err;
    logic ext_err;
    logic int_err;
    logic module_fault;
  } dgm_info_t;

  typedef struct packed {
    logic int_ind;
    logic ext_ind;
    logic group_ind;
    logic ch1_ind;
    logic ch2_ind;
  } dgm_leds_t;
endpackage

// >>> rtl/dgm_selftest.sv
`timescale 1ns/1ps
`include "dgm_cfg.svh"
module dgm_selftest #(
  parameter int DEPTH = `DGM_RAM_DEPTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic inject_i,
  output logic done_o,
  output logic pass_o
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] ram [DEPTH];
  logic [1:0] phase_q;
  logic [AW:0] idx_q;
  logic ok_q;
  logic [7:0] sig_q;

  function automatic logic [7:0] rom_word(input logic [3:0] i);
    return {i, ~i};
  endfunction

  function automatic logic [7:0] pat(input logic [AW:0] a);
    return 8'(a) ^ `DGM_RAM_PAT;
  endfunction

  // ram is written then read back; program store is checked by signature
  always_ff @(posedge clk_i) begin
    if (phase_q == 2'd1) begin
      ram[idx_q[AW-1:0]] <= pat(idx_q) ^ {7'h0, inject_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      phase_q <= 2'd0;
      idx_q <= '0;
      ok_q <= 1'b1;
      sig_q <= 8'h0;
      done_o <= 1'b0;
      pass_o <= 1'b0;
    end else begin
      unique case (phase_q)
        2'd0: if (start_i && !done_o) begin
          phase_q <= 2'd1;
          idx_q <= '0;
        end
        2'd1: begin
          idx_q <= (idx_q == (AW+1)'(DEPTH - 1)) ? '0 : idx_q + 1'b1;
          if (idx_q == (AW+1)'(DEPTH - 1)) phase_q <= 2'd2;
        end
        2'd2: begin
          if (ram[idx_q[AW-1:0]] != pat(idx_q)) ok_q <= 1'b0;
          sig_q <= sig_q ^ rom_word(4'(idx_q));
          idx_q <= idx_q + 1'b1;
          if (idx_q == (AW+1)'(DEPTH - 1)) phase_q <= 2'd3;
        end
        2'd3: begin
          done_o <= 1'b1;
          pass_o <= ok_q && (sig_q == `DGM_ROM_SIG);
          phase_q <= 2'd0;
        end
      endcase
    end
  end
endmodule

// >>> rtl/dgm_tick.sv
`timescale 1ns/1ps
module dgm_tick #(
  parameter int DIV = 20000
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  output logic tick_o
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == 32'(DIV - 1)) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> tb/dgm_host.sv
`timescale 1ns/1ps
module dgm_host (
  input wire logic clk_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  input wire logic err_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'h0;
    stb_o = 1'h0;
    we_o = 1'h0;
    adr_o = 8'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // request held until ack or err is sampled; released address and data lines show the inverse, not stale data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clk_i);
    cyc_o <= 1'h1;
    stb_o <= 1'h1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'h1 && err_i !== 1'h1);
    q = dat_i;
    e = err_i;
    cyc_o <= 1'h0;
    stb_o <= 1'h0;
    we_o <= 1'h0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
  // handler: interrupt register, then start info, detail record only when it names an error
  task automatic service(output logic [31:0] irq, output logic [31:0] info, output logic [31:0] det);
    logic e;
    logic [31:0] dummy;
    xfer(1'h0, 8'h08, 32'h0, irq, e);
    xfer(1'h0, 8'h0c, 32'h0, info, e);
    det = 32'h0;
    if (info[0]) xfer(1'h0, 8'h10, 32'h0, det, e);
    xfer(1'h1, 8'h08, 32'h1, dummy, e);
  endtask
endmodule

// >>> tb/dgm_monitor_asserts.sv
`timescale 1ns/1ps
module dgm_monitor_asserts #(
  parameter int NERR = 8
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [NERR-1:0] ERR_SRC_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic INT_FAULT_O,
  input wire logic DIAG_INT_O,
  input wire logic POS_ABORT_O,
  input wire logic SYNC_CLR_O,
  input wire logic OUT_EN_O,
  input wire logic TRAVERSE_OK_O,
  input wire logic READY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // both steps of readiness must hold, else a late ready edge looks like a new error
  sequence s_new_err;
    READY_O && $past(READY_O) && ((ERR_SRC_I & ~$past(ERR_SRC_I)) != '0);
  endsequence
  sequence s_new_range;
    READY_O && $past(READY_O) && ((ERR_SRC_I[5:4] & ~$past(ERR_SRC_I[5:4])) != 2'h0);
  endsequence
  a_bus_answer: assert property (CYC_I && STB_I && !ACK_O && !ERR_O |=> ACK_O ^ ERR_O)
    else $error("bus request not answered by exactly one of ack or err");
  a_answer_pulse: assert property (ACK_O || ERR_O |=> !ACK_O && !ERR_O)
    else $error("bus answer longer than one cycle");
  a_data_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data driven without ack");
  a_ready_stays: assert property (READY_O |=> READY_O)
    else $error("ready dropped without reset");
  a_startup_int_lit: assert property (!READY_O |-> INT_FAULT_O)
    else $error("internal indicator dark before ready");
  a_abort_new: assert property (s_new_err |-> ##[1:2] POS_ABORT_O)
    else $error("no abort after new error");
  a_sync_range: assert property (s_new_range |-> ##[1:2] SYNC_CLR_O)
    else $error("no sync clear after range or feedback error");
  a_outs_off: assert property (POS_ABORT_O |-> !OUT_EN_O)
    else $error("outputs enabled during abort");
  a_no_traverse: assert property (POS_ABORT_O |-> !TRAVERSE_OK_O)
    else $error("traverse allowed during abort");
  a_irq_holds: assert property (DIAG_INT_O && !CYC_I && !$past(CYC_I) |=> DIAG_INT_O)
    else $error("interrupt request dropped without host ack");
  a_irq_ready: assert property ($rose(DIAG_INT_O) |-> READY_O)
    else $error("interrupt raised by a device not running");
endmodule

bind dgm_monitor dgm_monitor_asserts #(.NERR(NERR)) i_dgm_monitor_asserts (.CLK_I, .NRST_I, .CYC_I, .STB_I,
  .ERR_SRC_I, .DAT_O, .ACK_O, .ERR_O, .INT_FAULT_O, .DIAG_INT_O, .POS_ABORT_O, .SYNC_CLR_O, .OUT_EN_O,
  .TRAVERSE_OK_O, .READY_O);

// >>> tb/dgm_monitor_bench.sv
`timescale 1ns/1ps
module dgm_monitor_bench;
  logic clk, nrst, inject, cyc, stb, we, ack, err, e, en, run, oreq, inc;
  logic [7:0] err_src, err_ch2, rep, adr, old;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, info, det;
  logic lint, lext, lgrp, lch1, lch2, irq, abrt, sclr, oen, trav, jog, rdy;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h2f506470;
  dgm_monitor #(.TICK_CYC(4), .LAMP_MS(2)) i_dgm_monitor (.CLK_I(clk), .NRST_I(nrst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .ERR_O(err),
    .ERR_SRC_I(err_src), .ERR_CH2_I(err_ch2), .TEST_INJECT_I(inject), .INT_FAULT_O(lint), .EXT_FAULT_O(lext),
    .GROUP_FAULT_O(lgrp), .CH1_O(lch1), .CH2_O(lch2), .DIAG_INT_O(irq), .POS_ABORT_O(abrt),
    .SYNC_CLR_O(sclr), .OUT_EN_O(oen), .TRAVERSE_OK_O(trav), .JOG_OK_O(jog), .READY_O(rdy));
  dgm_host i_dgm_host (.clk_i(clk), .dat_i(rdat), .ack_i(ack), .err_i(err), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task summarize;
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR %s expected %h got %h", n, x, g);
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      chk("timeout", 32'h0, 32'h1);
      summarize();
    end
  end
  function automatic logic [4:0] exp_leds(input logic [7:0] p, input logic [7:0] c);
    return {p[7], |(p & 8'h7f), |p, |(p & 8'h7c & ~c), |(p & 8'h7c & c)};
  endfunction
  // spare byte is left out of the comparison, nothing defines it
  function automatic logic [31:0] exp_info(input logic [7:0] p, input logic [7:0] c);
    return {6'h0, |(p & 8'h7c & c), |(p & 8'h7c & ~c), p, 8'h0, 4'h0, |(p & 8'h7c), |(p & 8'h7f), p[7], |p};
  endfunction
  task ctrl(input logic [3:0] v);
    en = v[0];
    run = v[2];
    inc = v[1];
    oreq = v[3];
    i_dgm_host.xfer(1'h1, 8'h00, {28'h0, v}, q, e);
  endtask
  task step(input logic [7:0] p, input logic [7:0] c);
    logic x;
    x = en && run && ((p != 8'h0 && p != rep) || (p == 8'h0 && rep != 8'h0));
    @(posedge clk);
    err_src <= p;
    err_ch2 <= c;
    repeat (3) @(posedge clk);
    chk("abort", 32'(|(p & ~old)), 32'(abrt));
    chk("sync_clr", 32'(|(p & ~old & (inc ? 8'h3f : 8'h30))), 32'(sclr));
    old = p;
    repeat (2) @(posedge clk);
    chk("irq", 32'(x), 32'(irq));
    chk("leds", 32'(exp_leds(p, c)), 32'({lint, lext, lgrp, lch1, lch2}));
    chk("outs", 32'({oreq && p == 8'h0, p == 8'h0, (p & 8'haf) == 8'h0}), 32'({oen, trav, jog}));
    if (x) begin
      rep = p;
      i_dgm_host.service(q, info, det);
      chk("outgoing", 32'(p == 8'h0), 32'(q[1]));
      chk("info", exp_info(p, c), info & 32'hffff00ff);
      chk("detail", {24'h0, p}, det);
    end
  endtask
  initial begin
    nrst = 1'h0;
    inject = 1'h0;
    err_src = 8'h0;
    err_ch2 = 8'h0;
    en = 1'h0;
    run = 1'h0;
    rep = 8'h0;
    old = 8'h0;
    inc = 1'h0;
    oreq = 1'h0;
    repeat (12) @(posedge clk);
    chk("reset_lamps", 32'h3, 32'({lint, lext}));
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    chk("lamp_test", 32'h3, 32'({lint, lext}));
    repeat (15) @(posedge clk);
    chk("test_lamps", 32'h2, 32'({lint, lext}));
    for (int n = 0; n < 300 && rdy !== 1'h1; n++) @(posedge clk);
    chk("ready", 32'h1, 32'(rdy));
    repeat (3) @(posedge clk);
    chk("lamps_off", 32'h0, 32'({lint, lext}));
    i_dgm_host.xfer(1'h0, 8'h40, 32'h0, q, e);
    chk("unmapped", 32'h1, 32'(e));
    ctrl(4'hf);
    step(8'h10, 8'h0);
    step(8'h50, 8'h40);
    step(8'h40, 8'h40);
    step(8'h0, 8'h0);
    for (int i = 0; i < 24; i++) step(8'($random(seed)), 8'($random(seed)));
    step(8'h0, 8'h0);
    ctrl(4'h4);
    step(8'h81, 8'h0);
    step(8'h0, 8'h0);
    ctrl(4'hb);
    step(8'h01, 8'h0);
    ctrl(4'hf);
    repeat (5) @(posedge clk);
    chk("run_resignal", 32'h1, 32'(irq));
    i_dgm_host.service(q, info, det);
    ctrl(4'hb);
    step(8'h0, 8'h0);
    ctrl(4'hf);
    repeat (5) @(posedge clk);
    chk("run_clean", 32'h0, 32'(irq));
    nrst <= 1'h0;
    inject <= 1'h1;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    repeat (300) @(posedge clk);
    chk("fail_ready", 32'h0, 32'(rdy));
    chk("fail_int", 32'h1, 32'(lint));
    i_dgm_host.xfer(1'h0, 8'h0c, 32'h0, q, e);
    chk("fail_refuse", 32'h1, 32'(e));
    summarize();
  end
endmodule
